// ### core/pulse_measure_emit.sv
// pulse width measurement and timed pulse emission on pins
`timescale 1ns/1ps
// Contract
// - measure times one pulse on the pin and returns count in units
// - edge select 1 starts on rising edge, 0 on falling edge
// - no completed pulse before timeout returns zero
// - unit and timeout scale inversely with clock speed setting
// - emit accepts length 0 to 65535 units, scaled with clock
// - emitted pulse is inverse of prior output level
// - emit forces pin direction to output on the same clock edge that the pulse starts
// - success result lies in 1 to 65535; timeout gives zero
module pulse_measure_emit
  import pulse_timing_pkg::*;
#(
  parameter int unsigned BASE_CYC = UNIT_CYC_AT_REF
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // measure request and answer
  input  wire logic               meas_start,
  input  wire measure_req_t       meas_req,
  output logic                    meas_busy,
  output logic                    meas_done,
  output logic [COUNT_W-1:0]      meas_result,
  // emit request and answer
  input  wire logic               emit_start,
  input  wire emit_req_t          emit_req,
  output logic                    emit_busy,
  output logic                    emit_done,
  // measured pin
  input  wire logic               meas_pin_in,
  // emitted pin
  input  wire logic               emit_level_idle,
  output logic                    emit_pin_out,
  output logic                    emit_pin_oe
);
  typedef enum logic [1:0] {M_IDLE, M_ARM, M_TIME} meas_state_t;
  typedef enum logic [0:0] {E_IDLE, E_PULSE} emit_state_t;

  meas_state_t        m_state_r;
  emit_state_t        e_state_r;
  logic               m_rise_r;
  logic [SPEED_W-1:0] m_speed_r;
  logic [SPEED_W-1:0] e_speed_r;
  logic               pin_prev_r;
  logic [COUNT_W-1:0] m_cnt_r;
  logic [COUNT_W-1:0] to_cnt_r;
  logic [COUNT_W-1:0] e_cnt_r;
  logic               e_level_r;
  logic               e_oe_r;
  logic               m_tick;
  logic               e_tick;
  logic               start_edge;
  logic               end_edge;
  logic               timeout;

  initial begin
    if (BASE_CYC < (1 << SPEED_MAX)) $error("pulse_measure_emit: bad BASE_CYC");
  end

  unit_tick #(.BASE_CYC(BASE_CYC)) u_meas_tick (
    .clk    (clk),
    .sys_rst(sys_rst),
    .run    (m_state_r != M_IDLE),
    .speed  (m_speed_r),
    .tick   (m_tick)
  );

  unit_tick #(.BASE_CYC(BASE_CYC)) u_emit_tick (
    .clk    (clk),
    .sys_rst(sys_rst),
    .run    (e_state_r == E_PULSE),
    .speed  (e_speed_r),
    .tick   (e_tick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) pin_prev_r <= 1'b0;
    else pin_prev_r <= meas_pin_in;
  end

  assign start_edge = m_rise_r ? (!pin_prev_r && meas_pin_in) : (pin_prev_r && !meas_pin_in);
  assign end_edge   = m_rise_r ? (pin_prev_r && !meas_pin_in) : (!pin_prev_r && meas_pin_in);
  assign timeout    = m_tick && (to_cnt_r == COUNT_MAX);
  assign meas_busy  = (m_state_r != M_IDLE);

  // measure state and timeout window, one timeout per request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m_state_r <= M_IDLE;
      m_rise_r  <= 1'b0;
      m_speed_r <= '0;
      m_cnt_r   <= COUNT_ZERO;
      to_cnt_r  <= COUNT_ZERO;
    end else begin
      case (m_state_r)
        M_IDLE: begin
          if (meas_start) begin
            m_state_r <= M_ARM;
            m_rise_r  <= meas_req.edge_rise;
            m_speed_r <= (meas_req.speed > 3'(SPEED_MAX)) ? 3'(SPEED_MAX) : meas_req.speed;
            m_cnt_r   <= COUNT_ZERO;
            to_cnt_r  <= COUNT_ZERO;
          end
        end
        M_ARM: begin
          if (m_tick) to_cnt_r <= to_cnt_r + 16'h0001;
          if (timeout) m_state_r <= M_IDLE;
          else if (start_edge) m_state_r <= M_TIME;
        end
        M_TIME: begin
          if (m_tick) to_cnt_r <= to_cnt_r + 16'h0001;
          if (m_tick && m_cnt_r != COUNT_MAX) m_cnt_r <= m_cnt_r + 16'h0001;
          if (end_edge || timeout) m_state_r <= M_IDLE;
        end
        default: m_state_r <= M_IDLE;
      endcase
    end
  end

  // measure answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meas_done   <= 1'b0;
      meas_result <= COUNT_ZERO;
    end else begin
      meas_done <= 1'b0;
      if (m_state_r == M_TIME && end_edge && !timeout) begin
        meas_done   <= 1'b1;
        meas_result <= (m_cnt_r == COUNT_ZERO) ? 16'h0001 : m_cnt_r;
      end else if (m_state_r != M_IDLE && timeout) begin
        meas_done   <= 1'b1;
        meas_result <= COUNT_ZERO;
      end
    end
  end

  assign emit_busy    = (e_state_r == E_PULSE);
  assign emit_pin_out = e_level_r;
  assign emit_pin_oe  = e_oe_r;

  // emit sequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      e_state_r <= E_IDLE;
      e_speed_r <= '0;
      e_cnt_r   <= COUNT_ZERO;
      e_level_r <= 1'b0;
      e_oe_r    <= 1'b0;
      emit_done <= 1'b0;
    end else begin
      emit_done <= 1'b0;
      case (e_state_r)
        E_IDLE: begin
          if (!e_oe_r) e_level_r <= emit_level_idle;
          if (emit_start) begin
            e_oe_r <= 1'b1;
            e_speed_r <= (emit_req.speed > 3'(SPEED_MAX)) ? 3'(SPEED_MAX) : emit_req.speed;
            if (emit_req.length == COUNT_ZERO) begin
              emit_done <= 1'b1;
            end else begin
              e_cnt_r   <= emit_req.length;
              e_level_r <= !(e_oe_r ? e_level_r : emit_level_idle);
              e_state_r <= E_PULSE;
            end
          end
        end
        E_PULSE: begin
          if (e_tick) begin
            e_cnt_r <= e_cnt_r - 16'h0001;
            if (e_cnt_r == 16'h0001) begin
              e_level_r <= !e_level_r;
              emit_done <= 1'b1;
              e_state_r <= E_IDLE;
            end
          end
        end
        default: e_state_r <= E_IDLE;
      endcase
    end
  end

  chk_timeout_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_busy && timeout) |=> (meas_done && meas_result == COUNT_ZERO))
    else $error("timeout did not give zero");
  chk_result_nonzero: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(m_state_r) == M_TIME && meas_done && !$past(timeout)) |-> meas_result != COUNT_ZERO)
    else $error("measured pulse gave zero");
  chk_stop_edge: assert property (@(posedge clk) disable iff (sys_rst)
    (m_state_r == M_TIME && end_edge) |=> (m_state_r == M_IDLE && meas_done))
    else $error("measure missed ending edge");
  chk_start_rise: assert property (@(posedge clk) disable iff (sys_rst)
    (m_state_r == M_ARM && m_rise_r && $rose(meas_pin_in) && !timeout) |=> m_state_r == M_TIME)
    else $error("rising start edge not taken");
  chk_count_grow: assert property (@(posedge clk) disable iff (sys_rst)
    (m_state_r == M_TIME && m_tick && m_cnt_r != COUNT_MAX && !end_edge && !timeout) |=>
      m_cnt_r == $past(m_cnt_r) + 16'h0001)
    else $error("measure count did not advance");
  chk_start_fall: assert property (@(posedge clk) disable iff (sys_rst)
    (m_state_r == M_ARM && !m_rise_r && $fell(meas_pin_in) && !timeout) |=> m_state_r == M_TIME)
    else $error("falling start edge not taken");
  chk_arm_wait: assert property (@(posedge clk) disable iff (sys_rst)
    (m_state_r == M_ARM && !timeout && !(m_rise_r ? $rose(meas_pin_in) : $fell(meas_pin_in))) |=> m_state_r == M_ARM)
    else $error("measure started on wrong edge");
  chk_emit_invert: assert property (@(posedge clk) disable iff (sys_rst)
    (e_state_r == E_IDLE && emit_start && emit_req.length != COUNT_ZERO) |=>
      emit_pin_out == !($past(e_oe_r) ? $past(emit_pin_out) : $past(emit_level_idle)))
    else $error("pulse not inverted");
  chk_emit_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (e_state_r == E_IDLE && emit_start && emit_req.length == COUNT_ZERO) |=> (emit_done && e_state_r == E_IDLE))
    else $error("zero length emit not finished");
  chk_emit_oe: assert property (@(posedge clk) disable iff (sys_rst)
    (e_state_r == E_IDLE && emit_start) |=> emit_pin_oe)
    else $error("pin not made output");
  chk_emit_restore: assert property (@(posedge clk) disable iff (sys_rst)
    (e_state_r == E_PULSE && e_tick && e_cnt_r == 16'h0001) |=> (emit_done && emit_pin_out != $past(emit_pin_out)))
    else $error("pulse end not restored");
  chk_emit_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (e_state_r == E_PULSE && !e_tick) |=> emit_pin_out == $past(emit_pin_out))
    else $error("pulse level moved early");
endmodule : pulse_measure_emit

// ### core/pulse_timing_pkg.sv
// package: constants and carriers for the pulse measure and emit block
package pulse_timing_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned REF_HZ         = 4_000_000;
  localparam int unsigned UNIT_NS_AT_REF = 10_000;
  localparam int unsigned CLK_NS         = 4;
  localparam int unsigned SPEED_W        = 3;
  localparam int unsigned SPEED_MAX      = 4;
  localparam int unsigned UNIT_CYC_AT_REF = UNIT_NS_AT_REF / CLK_NS;
  localparam int unsigned COUNT_W        = 16;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  typedef struct packed {
    logic                 edge_rise;
    logic [SPEED_W-1:0]   speed;
  } measure_req_t;

  typedef struct packed {
    logic [COUNT_W-1:0]   length;
    logic [SPEED_W-1:0]   speed;
  } emit_req_t;
endpackage : pulse_timing_pkg

// ### core/unit_tick.sv
// time unit tick generator scaled by clock speed setting
`timescale 1ns/1ps
module unit_tick
  import pulse_timing_pkg::*;
#(
  parameter int unsigned BASE_CYC = UNIT_CYC_AT_REF
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // control
  input  wire logic               run,
  input  wire logic [SPEED_W-1:0] speed,
  // tick out
  output logic                    tick
);
  initial begin
    if (BASE_CYC < (1 << SPEED_MAX) || BASE_CYC > 65535) $error("unit_tick: bad BASE_CYC");
  end

  logic [15:0] div_r;
  logic [15:0] limit;

  always_comb begin
    limit = 16'(BASE_CYC >> speed) - 16'h0001;
  end

  assign tick = run && (div_r == limit);

  always_ff @(posedge clk) begin
    if (sys_rst || !run || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
endmodule : unit_tick

// ### testbench/pin_source.sv
// far side model: signal source that drives the measured pin
`timescale 1ns/1ps
module pin_source (
  // clock
  input  wire logic        clk,
  // command from the bench
  input  wire logic        go,
  input  wire logic        idle_lvl,
  input  wire logic [15:0] width,
  // measured pin
  output logic             pin
);
  int cnt = 0;
  initial pin = 1'b0;
  always @(posedge clk) begin
    if (go) begin
      cnt <= int'(width) + 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    // rests at the idle level, inverted for width cycles once per command
    pin <= (cnt > 0 && cnt <= int'(width)) ? ~idle_lvl : idle_lvl;
  end
endmodule : pin_source

// ### testbench/pulse_width_measure_and_emit_test.sv
// self-checking testbench for the pulse measure and emit block
`timescale 1ns/1ps
module pulse_width_measure_and_emit_test;
  import pulse_timing_pkg::*;
  localparam int unsigned BC = 16;
  logic               clk, sys_rst, meas_start, emit_start, emit_level_idle, src_go, src_idle;
  logic               meas_busy, meas_done, emit_busy, emit_done, emit_pin_out, emit_pin_oe, meas_pin_in;
  logic [COUNT_W-1:0] meas_result, src_width;
  measure_req_t       meas_req;
  emit_req_t          emit_req;
  int                 fails = 0;
  int                 compares = 0;
  integer             seed = 32'hf27e8b70;

  pulse_measure_emit #(.BASE_CYC(BC)) uut (.clk(clk), .sys_rst(sys_rst), .meas_start(meas_start),
    .meas_req(meas_req), .meas_busy(meas_busy), .meas_done(meas_done), .meas_result(meas_result),
    .emit_start(emit_start), .emit_req(emit_req), .emit_busy(emit_busy), .emit_done(emit_done),
    .meas_pin_in(meas_pin_in), .emit_level_idle(emit_level_idle), .emit_pin_out(emit_pin_out),
    .emit_pin_oe(emit_pin_oe));
  pin_source src (.clk(clk), .go(src_go), .idle_lvl(src_idle), .width(src_width), .pin(meas_pin_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic int unit_of(input int s);
    return BC >> ((s > 4) ? 4 : s);
  endfunction : unit_of

  task automatic do_reset(input logic idle);
    sys_rst <= 1'b1;
    emit_level_idle <= idle;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic measure(input logic rise, input int s, input logic idle, input int w, input int exp);
    int n;
    int nb;
    logic [COUNT_W-1:0] res;
    src_idle <= idle;
    src_width <= 16'(w);
    repeat (4) @(posedge clk);
    meas_req <= {rise, 3'(s)};
    meas_start <= 1'b1;
    src_go <= 1'b1;
    @(posedge clk);
    meas_start <= 1'b0;
    src_go <= 1'b0;
    n = 0;
    nb = 0;
    while (meas_done !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
      if (meas_busy === 1'b1) nb++;
    end
    if (n >= 70000) begin
      fails++;
      final_report();
    end
    res = meas_result;
    if (exp != 0 && res != 0 && res + 1 >= exp && res <= exp + 1) res = 16'(exp);
    check(32'(res), 32'(exp));
    check(32'(nb), 32'(n - 1));
    @(posedge clk);
    check({meas_done, meas_busy}, 2'b00);
  endtask : measure

  task automatic emit(input int len, input int s, input logic prior);
    int n;
    int inv;
    int bsy;
    @(posedge clk);
    emit_req <= {16'(len), 3'(s)};
    emit_start <= 1'b1;
    @(posedge clk);
    emit_start <= 1'b0;
    n = 0;
    inv = 0;
    bsy = 0;
    while (emit_done !== 1'b1 && n < 70000) begin
      @(posedge clk);
      n++;
      if (emit_pin_out !== prior) inv++;
      if (emit_busy === 1'b1) bsy++;
    end
    if (n >= 70000) begin
      fails++;
      final_report();
    end
    check(32'(inv), 32'(len * unit_of(s)));
    check(32'(bsy), 32'(len * unit_of(s)));
    check({emit_pin_oe, emit_pin_out}, {1'b1, prior});
  endtask : emit

  initial begin
    sys_rst = 1'b1;
    meas_start = 1'b0;
    emit_start = 1'b0;
    meas_req = '0;
    emit_req = '0;
    emit_level_idle = 1'b1;
    src_go = 1'b0;
    src_idle = 1'b0;
    src_width = 16'h0000;
    do_reset(1'b1);
    @(posedge clk);
    check({emit_pin_oe, meas_busy, emit_busy, meas_done, emit_done}, 5'h00);
    emit(3, 4, 1'b1);
    for (int s = 0; s < 6; s++) begin
      emit(1 + ($random(seed) & 7), s, 1'b1);
    end
    emit(0, 0, 1'b1);
    do_reset(1'b0);
    check({emit_pin_oe, emit_pin_out}, 2'b00);
    emit(5, 2, 1'b0);
    for (int s = 0; s < 6; s++) begin
      int k;
      k = 2 + ($random(seed) & 7);
      measure(s[0], s, ~s[0], k * unit_of(s), k);
    end
    measure(1'b0, 0, 1'b1, 3, 1);
    measure(1'b1, 4, 1'b1, 5, 0);
    final_report();
  end
endmodule : pulse_width_measure_and_emit_test
